// [pxu_process_exchange_unit.sv]
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module pxu_process_exchange_unit
	import pxu_pkg::*;
#(
	parameter logic [15:0] OPC_WAIT = 16'h0001,
	parameter logic [15:0] OPC_NOTIFY_ENQUEUE_TAIL = 16'h0002,
	parameter logic [15:0] OPC_NOTIFY_ENQUEUE_HEAD = 16'h0003
) (
	input  wire logic         clk_sys,
	input  wire logic         reset_n,
	input  wire logic         ce,
	input  wire logic [7:0]   regAddr,
	input  wire logic [31:0]  regWdata,
	input  wire logic         regWe,
	input  wire logic         regRe,
	output pxu_ptr_t          regRdata,
	input  wire logic         instrValid,
	input  wire logic [47:0]  instrWord,
	input  wire logic [1:0]   execRing,
	input  wire logic         resumeReq,
	output pxu_mem_cmd_t      memCmd,
	input  wire logic         memAck,
	input  wire logic [15:0]  memRdata,
	output pxu_ptr_t          curPtr,
	output pxu_ptr_t          nextPtr,
	output logic              instrDone,
	output logic              runContinue,
	output logic              preempt,
	output logic              shortSave,
	output logic              faultRestricted,
	output logic              faultOverflow,
	output logic              faultUnderflow
);

	// ------------------------------------------------------------
	// Parameter check
	// ------------------------------------------------------------
	if (OPC_WAIT == OPC_NOTIFY_ENQUEUE_TAIL || OPC_WAIT == OPC_NOTIFY_ENQUEUE_HEAD ||
	    OPC_NOTIFY_ENQUEUE_TAIL == OPC_NOTIFY_ENQUEUE_HEAD) begin : g_bad_opcodes
		$error("Opcodes must be distinct");
	end

	// ------------------------------------------------------------
	// Reset synchroniser
	// ------------------------------------------------------------
	logic rstMeta_q;
	logic rstSync_n;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rstMeta_q <= 1'b0;
			rstSync_n <= 1'b0;
		end else begin
			rstMeta_q <= 1'b1;
			rstSync_n <= rstMeta_q;
		end
	end

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	pxu_state_t   state_q;
	pxu_ptr_t     cur_q;
	pxu_ptr_t     next_q;
	pxu_mem_cmd_t memCmd_q;
	pxu_mem_cmd_t memCmd_d;
	logic [15:0]  descSeg_q;
	logic [31:0]  semAddr_q;
	logic [31:0]  loc_q;
	logic [15:0]  cntNew_q;
	logic [15:0]  work_q;
	logic [15:0]  nd_q;
	logic [15:0]  nlv_q;
	logic [15:0]  oldHead_q;
	logic         isWait_q;
	logic         atHead_q;
	logic         memState;
	logic         memDone;
	logic [15:0]  opcode;
	logic         isPxuOp;
	logic         takeOp;
	logic         takeResume;

	assign opcode  = instrWord[47:32];
	assign isPxuOp = opcode == OPC_WAIT || opcode == OPC_NOTIFY_ENQUEUE_TAIL ||
	                 opcode == OPC_NOTIFY_ENQUEUE_HEAD;
	// Done cycle blocks a retake of a request still held high
	assign takeOp     = instrValid && !instrDone;
	assign takeResume = !instrValid && !instrDone && resumeReq;
	assign memDone = memCmd_q.req & memAck;
	assign memState = !(state_q == PXU_IDLE || state_q == PXU_PICK ||
	                    state_q == PXU_FIN);

	function automatic logic [31:0] dsc(input logic [15:0] w);
		return {descSeg_q, w};
	endfunction

	// ------------------------------------------------------------
	// Memory access per state
	// ------------------------------------------------------------
	always_comb begin
		memCmd_d = '0;
		memCmd_d.req = memState;
		case (state_q)
			PXU_RDCNT: memCmd_d.addr = semAddr_q;
			PXU_WRCNT: begin
				memCmd_d.we    = 1'b1;
				memCmd_d.addr  = semAddr_q;
				memCmd_d.wdata = cntNew_q;
			end
			PXU_W_RDLINK: memCmd_d.addr = dsc(cur_q.addr + PXU_DW_LINK);
			PXU_W_WRHEAD: begin
				memCmd_d.we    = 1'b1;
				memCmd_d.addr  = dsc(cur_q.level);
				memCmd_d.wdata = work_q;
			end
			PXU_W_WRTAIL: begin
				memCmd_d.we    = 1'b1;
				memCmd_d.addr  = dsc(cur_q.level + PXU_HDR_TAIL);
				memCmd_d.wdata = PXU_NULL;
			end
			PXU_W_WRSEG: begin
				memCmd_d.we    = 1'b1;
				memCmd_d.addr  = dsc(cur_q.addr + PXU_DW_SEMSEG);
				memCmd_d.wdata = semAddr_q[31:16];
			end
			PXU_W_WROFF: begin
				memCmd_d.we    = 1'b1;
				memCmd_d.addr  = dsc(cur_q.addr + PXU_DW_SEMOFF);
				memCmd_d.wdata = semAddr_q[15:0];
			end
			PXU_W_RDPTR: memCmd_d.addr = loc_q;
			PXU_W_RDLVL: memCmd_d.addr = dsc(work_q);
			PXU_W_LINKNEW: begin
				memCmd_d.we    = 1'b1;
				memCmd_d.addr  = dsc(cur_q.addr + PXU_DW_LINK);
				memCmd_d.wdata = work_q;
			end
			PXU_W_LINKPREV: begin
				memCmd_d.we    = 1'b1;
				memCmd_d.addr  = loc_q;
				memCmd_d.wdata = cur_q.addr;
			end
			PXU_SCAN: memCmd_d.addr = dsc(cur_q.level);
			PXU_N_RDHEAD: memCmd_d.addr = semAddr_q + PXU_SEM_HEAD;
			PXU_N_RDLINK: memCmd_d.addr = dsc(nd_q + PXU_DW_LINK);
			PXU_N_WRSEM: begin
				memCmd_d.we    = 1'b1;
				memCmd_d.addr  = semAddr_q + PXU_SEM_HEAD;
				memCmd_d.wdata = work_q;
			end
			PXU_N_CLRSEG: begin
				memCmd_d.we    = 1'b1;
				memCmd_d.addr  = dsc(nd_q + PXU_DW_SEMSEG);
				memCmd_d.wdata = PXU_NULL;
			end
			PXU_N_RDLVL: memCmd_d.addr = dsc(nd_q);
			PXU_N_RDHDR: memCmd_d.addr = dsc(nlv_q);
			PXU_N_RDTAIL: memCmd_d.addr = dsc(nlv_q + PXU_HDR_TAIL);
			PXU_N_WRTLINK: begin
				memCmd_d.we    = 1'b1;
				memCmd_d.addr  = dsc(work_q + PXU_DW_LINK);
				memCmd_d.wdata = nd_q;
			end
			PXU_N_WRLINK: begin
				memCmd_d.we    = 1'b1;
				memCmd_d.addr  = dsc(nd_q + PXU_DW_LINK);
				memCmd_d.wdata = atHead_q ? oldHead_q : PXU_NULL;
			end
			PXU_N_WRHD: begin
				memCmd_d.we    = 1'b1;
				memCmd_d.addr  = dsc(nlv_q);
				memCmd_d.wdata = nd_q;
			end
			PXU_N_WRTL: begin
				memCmd_d.we    = 1'b1;
				memCmd_d.addr  = dsc(nlv_q + PXU_HDR_TAIL);
				memCmd_d.wdata = nd_q;
			end
			default: memCmd_d.addr = '0;
		endcase
	end

	// Request held until acknowledged; dropped one cycle between steps
	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			memCmd_q <= '0;
		end else if (ce) begin
			if (memCmd_q.req) begin
				if (memAck) begin
					memCmd_q.req <= 1'b0;
				end
			end else if (memState) begin
				memCmd_q <= memCmd_d;
			end
		end
	end

	// ------------------------------------------------------------
	// Exchange sequencer
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			state_q         <= PXU_IDLE;
			cur_q           <= PXU_PTR_RST;
			next_q          <= PXU_PTR_RST;
			descSeg_q       <= PXU_SEG_RST;
			semAddr_q       <= '0;
			loc_q           <= '0;
			cntNew_q        <= '0;
			work_q          <= '0;
			nd_q            <= '0;
			nlv_q           <= '0;
			oldHead_q       <= '0;
			isWait_q        <= 1'b0;
			atHead_q        <= 1'b0;
			instrDone       <= 1'b0;
			runContinue     <= 1'b0;
			preempt         <= 1'b0;
			shortSave       <= 1'b0;
			faultRestricted <= 1'b0;
			faultOverflow   <= 1'b0;
			faultUnderflow  <= 1'b0;
		end else if (ce) begin
			instrDone       <= 1'b0;
			runContinue     <= 1'b0;
			preempt         <= 1'b0;
			shortSave       <= 1'b0;
			faultRestricted <= 1'b0;
			faultOverflow   <= 1'b0;
			faultUnderflow  <= 1'b0;
			case (state_q)
				PXU_IDLE: begin
					// Pointer writes only accepted while idle
					if (regWe && regAddr == PXU_OFS_CUR) begin
						cur_q <= regWdata;
						if (regWdata[15:0] == PXU_NULL) begin
							next_q.addr <= PXU_NULL;
						end
					end
					if (regWe && regAddr == PXU_OFS_NEXT) begin
						next_q.level <= regWdata[31:16];
						next_q.addr  <= cur_q.addr == PXU_NULL ?
						                PXU_NULL : regWdata[15:0];
					end
					if (regWe && regAddr == PXU_OFS_SEG) begin
						descSeg_q <= regWdata[15:0];
					end
					if (takeOp && isPxuOp) begin
						if (execRing != PXU_RING0) begin
							faultRestricted <= 1'b1;
							instrDone       <= 1'b1;
						end else begin
							semAddr_q <= instrWord[31:0];
							isWait_q  <= opcode == OPC_WAIT;
							atHead_q  <= opcode == OPC_NOTIFY_ENQUEUE_HEAD;
							state_q   <= PXU_RDCNT;
						end
					end else if (takeOp) begin
						instrDone <= 1'b1;
					end else if (takeResume) begin
						state_q <= PXU_PICK;
					end
				end
				PXU_RDCNT: if (memDone) begin
					if (isWait_q && memRdata == PXU_CNT_MAX) begin
						faultOverflow <= 1'b1;
						instrDone     <= 1'b1;
						state_q       <= PXU_IDLE;
					end else if (!isWait_q && memRdata == PXU_CNT_MIN) begin
						faultUnderflow <= 1'b1;
						instrDone      <= 1'b1;
						state_q        <= PXU_IDLE;
					end else begin
						cntNew_q <= isWait_q ? memRdata + PXU_CNT_ONE :
						            memRdata - PXU_CNT_ONE;
						state_q  <= PXU_WRCNT;
					end
				end
				PXU_WRCNT: if (memDone) begin
					// Sign of the new count selects stop or go
					if (isWait_q && $signed(cntNew_q) > 0) begin
						shortSave <= 1'b1;
						state_q   <= PXU_W_RDLINK;
					end else if (!isWait_q && !cntNew_q[15]) begin
						state_q <= PXU_N_RDHEAD;
					end else begin
						runContinue <= 1'b1;
						instrDone   <= 1'b1;
						state_q     <= PXU_IDLE;
					end
				end
				// Running descriptor is always head of its level
				PXU_W_RDLINK: if (memDone) begin
					work_q  <= memRdata;
					state_q <= PXU_W_WRHEAD;
				end
				PXU_W_WRHEAD: if (memDone) begin
					state_q <= work_q == PXU_NULL ? PXU_W_WRTAIL :
					           PXU_W_WRSEG;
				end
				PXU_W_WRTAIL: if (memDone) state_q <= PXU_W_WRSEG;
				PXU_W_WRSEG: if (memDone) state_q <= PXU_W_WROFF;
				PXU_W_WROFF: if (memDone) begin
					loc_q   <= semAddr_q + PXU_SEM_HEAD;
					state_q <= PXU_W_RDPTR;
				end
				PXU_W_RDPTR: if (memDone) begin
					work_q  <= memRdata;
					state_q <= memRdata == PXU_NULL ? PXU_W_LINKNEW :
					           PXU_W_RDLVL;
				end
				// Lower priority sits at a higher header address
				PXU_W_RDLVL: if (memDone) begin
					if (memRdata > cur_q.level) begin
						state_q <= PXU_W_LINKNEW;
					end else begin
						loc_q   <= dsc(work_q + PXU_DW_LINK);
						state_q <= PXU_W_RDPTR;
					end
				end
				PXU_W_LINKNEW: if (memDone) state_q <= PXU_W_LINKPREV;
				PXU_W_LINKPREV: if (memDone) state_q <= PXU_PICK;
				PXU_PICK: begin
					if (next_q.addr != PXU_NULL) begin
						cur_q       <= next_q;
						next_q.addr <= PXU_NULL;
						instrDone   <= 1'b1;
						state_q     <= PXU_IDLE;
					end else begin
						state_q <= PXU_SCAN;
					end
				end
				PXU_SCAN: if (memDone) begin
					if (memRdata == PXU_END_OF_LIST) begin
						cur_q.addr  <= PXU_NULL;
						next_q.addr <= PXU_NULL;
						instrDone   <= 1'b1;
						state_q     <= PXU_IDLE;
					end else if (memRdata == PXU_EMPTY_LEVEL) begin
						cur_q.level <= cur_q.level + PXU_HDR_STEP;
					end else begin
						cur_q.addr <= memRdata;
						instrDone  <= 1'b1;
						state_q    <= PXU_IDLE;
					end
				end
				PXU_N_RDHEAD: if (memDone) begin
					nd_q    <= memRdata;
					state_q <= PXU_N_RDLINK;
				end
				PXU_N_RDLINK: if (memDone) begin
					work_q  <= memRdata;
					state_q <= PXU_N_WRSEM;
				end
				PXU_N_WRSEM: if (memDone) state_q <= PXU_N_CLRSEG;
				PXU_N_CLRSEG: if (memDone) state_q <= PXU_N_RDLVL;
				PXU_N_RDLVL: if (memDone) begin
					nlv_q   <= memRdata;
					state_q <= PXU_N_RDHDR;
				end
				PXU_N_RDHDR: if (memDone) begin
					oldHead_q <= memRdata;
					state_q   <= (atHead_q || memRdata == PXU_EMPTY_LEVEL) ?
					             PXU_N_WRLINK : PXU_N_RDTAIL;
				end
				PXU_N_RDTAIL: if (memDone) begin
					work_q  <= memRdata;
					state_q <= PXU_N_WRTLINK;
				end
				PXU_N_WRTLINK: if (memDone) state_q <= PXU_N_WRLINK;
				PXU_N_WRLINK: if (memDone) begin
					state_q <= (atHead_q || oldHead_q == PXU_EMPTY_LEVEL) ?
					           PXU_N_WRHD : PXU_N_WRTL;
				end
				PXU_N_WRHD: if (memDone) begin
					state_q <= oldHead_q == PXU_EMPTY_LEVEL ? PXU_N_WRTL :
					           PXU_FIN;
				end
				PXU_N_WRTL: if (memDone) state_q <= PXU_FIN;
				PXU_FIN: begin
					if (cur_q.addr == PXU_NULL) begin
						cur_q <= {nlv_q, nd_q};
					end else if (nlv_q < cur_q.level) begin
						next_q  <= cur_q;
						cur_q   <= {nlv_q, nd_q};
						preempt <= 1'b1;
					end
					runContinue <= 1'b1;
					instrDone   <= 1'b1;
					state_q     <= PXU_IDLE;
				end
				default: state_q <= PXU_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Register read port
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			regRdata <= '0;
		end else if (ce) begin
			regRdata <= '0;
			if (regRe) begin
				case (regAddr)
					PXU_OFS_CUR:  regRdata <= cur_q;
					PXU_OFS_NEXT: regRdata <= next_q;
					PXU_OFS_SEG:  regRdata <= {16'h0000, descSeg_q};
					PXU_OFS_STAT: regRdata <= {30'h0, cur_q.addr == PXU_NULL,
					                           state_q != PXU_IDLE};
					default:      regRdata <= '0;
				endcase
			end
		end
	end

	assign memCmd  = memCmd_q;
	assign curPtr  = cur_q;
	assign nextPtr = next_q;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstSync_n);

	sequence s_scan_step;
		state_q == PXU_SCAN && memDone && ce;
	endsequence

	a_ring_check: assert property (
		(ce && state_q == PXU_IDLE && takeOp && isPxuOp &&
		 execRing != PXU_RING0) |=> faultRestricted && state_q == PXU_IDLE)
		else $error("Restricted op outside ring 0 not faulted");
	a_overflow_fault: assert property (
		(ce && state_q == PXU_RDCNT && memDone && isWait_q &&
		 memRdata == PXU_CNT_MAX) |=> faultOverflow && state_q == PXU_IDLE)
		else $error("Missing overflow fault");
	a_underflow_fault: assert property (
		(ce && state_q == PXU_RDCNT && memDone && !isWait_q &&
		 memRdata == PXU_CNT_MIN) |=> faultUnderflow)
		else $error("Missing underflow fault");
	a_wait_increment: assert property (
		(ce && state_q == PXU_RDCNT && memDone && isWait_q &&
		 memRdata != PXU_CNT_MAX) |=>
		cntNew_q == $past(memRdata) + PXU_CNT_ONE)
		else $error("Wait counter not incremented by one");
	a_stop_positive: assert property (
		(ce && state_q == PXU_WRCNT && memDone && isWait_q &&
		 $signed(cntNew_q) > 0) |=> state_q == PXU_W_RDLINK && shortSave)
		else $error("Positive wait count did not stop process");
	a_invalid_pair: assert property (
		cur_q.addr == PXU_NULL |-> next_q.addr == PXU_NULL)
		else $error("Next valid while current invalid");
	a_preempt_copy: assert property (
		$rose(preempt) |-> next_q == $past(cur_q) &&
		cur_q.level < next_q.level)
		else $error("Preemption did not save current pointer");
	a_end_of_list: assert property (
		(s_scan_step ##0 memRdata == PXU_END_OF_LIST) |=>
		cur_q.addr == PXU_NULL && state_q == PXU_IDLE)
		else $error("End of list not recognised");
	a_empty_level: assert property (
		(s_scan_step ##0 memRdata == PXU_EMPTY_LEVEL) |=>
		cur_q.level == $past(cur_q.level) + PXU_HDR_STEP)
		else $error("Empty level not skipped");
	a_equal_after: assert property (
		(ce && state_q == PXU_W_RDLVL && memDone &&
		 memRdata == cur_q.level) |=> state_q == PXU_W_RDPTR)
		else $error("Equal priority not passed over");

endmodule // pxu_process_exchange_unit

// [pxu_pkg.sv]
package pxu_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0]  PXU_OFS_CUR  = 8'h00;
	localparam logic [7:0]  PXU_OFS_NEXT = 8'h04;
	localparam logic [7:0]  PXU_OFS_SEG  = 8'h08;
	localparam logic [7:0]  PXU_OFS_STAT = 8'h0c;
	localparam logic [31:0] PXU_PTR_RST  = 32'h0000_0000;
	localparam logic [15:0] PXU_SEG_RST  = 16'h0000;

	// ------------------------------------------------------------
	// List and descriptor layout
	// ------------------------------------------------------------
	localparam logic [15:0] PXU_END_OF_LIST = 16'h0001;
	localparam logic [15:0] PXU_EMPTY_LEVEL = 16'h0000;
	localparam logic [15:0] PXU_NULL        = 16'h0000;
	localparam logic [15:0] PXU_HDR_STEP    = 16'h0002;
	localparam logic [15:0] PXU_HDR_TAIL    = 16'h0001;
	localparam logic [15:0] PXU_DW_LINK     = 16'h0001;
	localparam logic [15:0] PXU_DW_SEMSEG   = 16'h0002;
	localparam logic [15:0] PXU_DW_SEMOFF   = 16'h0003;
	localparam logic [31:0] PXU_SEM_HEAD    = 32'h0000_0001;
	localparam logic [15:0] PXU_CNT_MAX     = 16'h7fff;
	localparam logic [15:0] PXU_CNT_MIN     = 16'h8000;
	localparam logic [15:0] PXU_CNT_ONE     = 16'h0001;
	localparam logic [1:0]  PXU_RING0       = 2'h0;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [25:0] {
		PXU_IDLE       = 26'h0000001,
		PXU_RDCNT      = 26'h0000002,
		PXU_WRCNT      = 26'h0000004,
		PXU_W_RDLINK   = 26'h0000008,
		PXU_W_WRHEAD   = 26'h0000010,
		PXU_W_WRTAIL   = 26'h0000020,
		PXU_W_WRSEG    = 26'h0000040,
		PXU_W_WROFF    = 26'h0000080,
		PXU_W_RDPTR    = 26'h0000100,
		PXU_W_RDLVL    = 26'h0000200,
		PXU_W_LINKNEW  = 26'h0000400,
		PXU_W_LINKPREV = 26'h0000800,
		PXU_PICK       = 26'h0001000,
		PXU_SCAN       = 26'h0002000,
		PXU_N_RDHEAD   = 26'h0004000,
		PXU_N_RDLINK   = 26'h0008000,
		PXU_N_WRSEM    = 26'h0010000,
		PXU_N_CLRSEG   = 26'h0020000,
		PXU_N_RDLVL    = 26'h0040000,
		PXU_N_RDHDR    = 26'h0080000,
		PXU_N_RDTAIL   = 26'h0100000,
		PXU_N_WRTLINK  = 26'h0200000,
		PXU_N_WRLINK   = 26'h0400000,
		PXU_N_WRHD     = 26'h0800000,
		PXU_N_WRTL     = 26'h1000000,
		PXU_FIN        = 26'h2000000
	} pxu_state_t;

	typedef struct packed {
		logic [15:0] level;
		logic [15:0] addr;
	} pxu_ptr_t;

	typedef struct packed {
		logic        req;
		logic        we;
		logic [31:0] addr;
		logic [15:0] wdata;
	} pxu_mem_cmd_t;

endpackage

// [pxu_mem_model.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// Main memory: headers, descriptors and semaphores
// ------------------------------------------------------------
module pxu_mem_model
	import pxu_pkg::*;
(
	input  wire logic         clk_sys,
	input  wire pxu_mem_cmd_t memCmd,
	input  wire logic [2:0]   lat,
	output logic              memAck,
	output logic [15:0]       memRdata
);
	logic [15:0] mem [logic [31:0]];
	logic [2:0]  cnt;

	initial begin
		memAck = 1'b0;
		memRdata = 16'h0000;
		cnt = 3'h0;
	end

	// Data toggles on every cycle but a read ack of a stored word, so a stale read never looks right
	always @(posedge clk_sys) begin
		memRdata <= ~memRdata;
		if (memAck || !memCmd.req) begin
			memAck <= 1'b0;
			cnt <= 3'h0;
		end else if (cnt < lat) begin
			cnt <= cnt + 3'h1;
		end else begin
			memAck <= 1'b1;
			if (memCmd.we)
				mem[memCmd.addr] = memCmd.wdata;
			else if (mem.exists(memCmd.addr))
				memRdata <= mem[memCmd.addr];
		end
	end
endmodule // pxu_mem_model

// [pxu_process_exchange_unit_bench.sv]
`timescale 1ns/1ps
module pxu_process_exchange_unit_bench
	import pxu_pkg::*;
;
	logic         clk_sys, reset_n, regWe, regRe, instrValid, resumeReq;
	logic         memAck, instrDone, runContinue, preempt, shortSave;
	logic         faultRestricted, faultOverflow, faultUnderflow;
	logic [7:0]   regAddr;
	logic [31:0]  regWdata;
	logic [47:0]  instrWord;
	logic [1:0]   execRing;
	logic [2:0]   lat;
	logic [5:0]   fl;
	logic [15:0]  memRdata;
	pxu_ptr_t     regRdata, curPtr, nextPtr;
	pxu_mem_cmd_t memCmd;
	int           errors, n_checks, cyc, i;
	localparam logic [31:0] SEM = 32'h0002_0010;
	localparam logic [15:0] DS = 16'h0005;
	localparam logic [31:0] M = 32'hffff_ffff;
	// Cells in the descriptor segment: {word, value}
	logic [31:0] ini [8] = '{32'h0100_0040, 32'h0101_0060,
		32'h0102_0000, 32'h0104_0001, 32'h0040_0100,
		32'h0041_0060, 32'h0060_0100, 32'h0061_0000};

	pxu_process_exchange_unit u_pxu_process_exchange_unit (
		.clk_sys(clk_sys), .reset_n(reset_n), .ce(1'b1),
		.regAddr(regAddr), .regWdata(regWdata), .regWe(regWe),
		.regRe(regRe), .regRdata(regRdata), .instrValid(instrValid),
		.instrWord(instrWord), .execRing(execRing), .resumeReq(resumeReq),
		.memCmd(memCmd), .memAck(memAck), .memRdata(memRdata),
		.curPtr(curPtr), .nextPtr(nextPtr), .instrDone(instrDone),
		.runContinue(runContinue), .preempt(preempt),
		.shortSave(shortSave), .faultRestricted(faultRestricted),
		.faultOverflow(faultOverflow), .faultUnderflow(faultUnderflow));

	pxu_mem_model u_pxu_mem_model (.clk_sys(clk_sys), .memCmd(memCmd),
		.lat(lat), .memAck(memAck), .memRdata(memRdata));

	// ------------------------------------------------------------
	// Access tasks
	// ------------------------------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task mm(input logic [31:0] k, input logic [15:0] e);
		chk({16'h0000, u_pxu_mem_model.mem[k]}, {16'h0000, e});
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regWdata <= d;
		regWe <= 1'b1;
		@(posedge clk_sys);
		regWe <= 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		@(posedge clk_sys);
		regAddr <= a;
		regRe <= 1'b1;
		@(posedge clk_sys);
		regRe <= 1'b0;
		@(posedge clk_sys);
		chk(regRdata & m, e);
	endtask

	// Flags gathered over the whole operation, done checked last
	// With v low the call asks for a resume instead
	task op(input logic [15:0] c, input logic [1:0] r, input logic v = 1'b1);
		fl = 6'h00;
		@(posedge clk_sys);
		instrWord <= {c, SEM};
		execRing <= r;
		instrValid <= v;
		resumeReq <= !v;
		for (i = 0; i < 500; i++) begin
			@(posedge clk_sys);
			fl = fl | {runContinue, preempt, shortSave,
				faultRestricted, faultOverflow, faultUnderflow};
			if (instrDone === 1'b1)
				break;
		end
		instrValid <= 1'b0;
		resumeReq <= 1'b0;
		chk({31'h0, instrDone}, 32'h1);
	endtask

	task close_out;
		$display("errors=%0d n_checks=%0d", errors, n_checks);
		if (errors == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	always #50 clk_sys = ~clk_sys;

	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			close_out;
		end
	end

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		reset_n = 1'b0;
		{regWe, regRe, instrValid, regAddr, regWdata} = '0;
		{instrWord, execRing, resumeReq} = '0;
		lat = 3'h1;
		{errors, n_checks, cyc} = '0;
		repeat (10) @(posedge clk_sys);
		reset_n <= 1'b1;
		repeat (6) @(posedge clk_sys);
		rd(PXU_OFS_CUR, M, PXU_PTR_RST);
		rd(PXU_OFS_NEXT, M, PXU_PTR_RST);
		rd(PXU_OFS_SEG, M, 32'h0);
		rd(PXU_OFS_STAT, M, 32'h2);
		wr(PXU_OFS_NEXT, 32'h0102_0080);
		rd(PXU_OFS_NEXT, 32'hffff, 32'h0);
		wr(PXU_OFS_SEG, {16'h0000, DS});
		wr(PXU_OFS_CUR, 32'h0100_0040);
		wr(8'h10, M);
		rd(PXU_OFS_CUR, M, 32'h0100_0040);
		rd(PXU_OFS_SEG, M, {16'h0000, DS});
		rd(PXU_OFS_STAT, M, 32'h0);
		rd(8'h10, M, 32'h0);
		for (i = 0; i < 8; i++)
			u_pxu_mem_model.mem[{DS, ini[i][31:16]}] = ini[i][15:0];
		u_pxu_mem_model.mem[SEM] = 16'hffff;
		u_pxu_mem_model.mem[SEM + 1] = 16'h0000;
		op(16'h0001, 2'h1);
		chk(fl, 6'h04);
		mm(SEM, 16'hffff);
		lat <= 3'h3;
		op(16'h0001, 2'h0);
		chk(fl, 6'h20);
		mm(SEM, 16'h0000);
		u_pxu_mem_model.mem[SEM] = PXU_CNT_MAX;
		op(16'h0001, 2'h0);
		chk(fl, 6'h02);
		mm(SEM, PXU_CNT_MAX);
		u_pxu_mem_model.mem[SEM] = 16'h0000;
		lat <= 3'h1;
		op(16'h0001, 2'h0);
		chk(fl, 6'h08);
		mm(SEM, 16'h0001);
		mm(SEM + 1, 16'h0040);
		mm({DS, 16'h0041}, 16'h0000);
		mm({DS, 16'h0100}, 16'h0060);
		mm({DS, 16'h0042}, 16'h0002);
		mm({DS, 16'h0043}, 16'h0010);
		chk(curPtr, 32'h0100_0060);
		chk(nextPtr & 32'hffff, 32'h0);
		op(16'h0002, 2'h0);
		chk(fl, 6'h20);
		mm(SEM, 16'h0000);
		mm(SEM + 1, 16'h0000);
		mm({DS, 16'h0042}, 16'h0000);
		mm({DS, 16'h0061}, 16'h0040);
		mm({DS, 16'h0101}, 16'h0040);
		chk(curPtr, 32'h0100_0060);
		u_pxu_mem_model.mem[SEM] = PXU_CNT_MIN;
		op(16'h0003, 2'h0);
		chk(fl, 6'h01);
		mm(SEM, PXU_CNT_MIN);
		// Waiter of a lower level (higher priority), readied at the head of its level
		u_pxu_mem_model.mem[SEM] = 16'h0001;
		u_pxu_mem_model.mem[SEM + 1] = 16'h0080;
		u_pxu_mem_model.mem[{DS, 16'h0080}] = 16'h00fe;
		u_pxu_mem_model.mem[{DS, 16'h0081}] = 16'h0000;
		u_pxu_mem_model.mem[{DS, 16'h00fe}] = 16'h0000;
		op(16'h0003, 2'h0);
		chk(fl, 6'h30);
		chk(curPtr, 32'h00fe_0080);
		chk(nextPtr, 32'h0100_0060);
		mm({DS, 16'h00fe}, 16'h0080);
		mm({DS, 16'h00ff}, 16'h0080);
		op(16'h0000, 2'h0, 1'b0);
		chk(fl, 6'h00);
		chk(curPtr, 32'h0100_0060);
		chk(nextPtr & 32'hffff, 32'h0);
		// Scan from an empty level down to the end of the list
		wr(PXU_OFS_CUR, 32'h0102_0000);
		op(16'h0000, 2'h0, 1'b0);
		chk(curPtr, 32'h0104_0000);
		rd(PXU_OFS_STAT, M, 32'h2);
		close_out;
	end
endmodule // pxu_process_exchange_unit_bench
